// >>> cfg_host_model.sv
// Host bridge model issuing configuration cycles
module cfg_host_model (
  input wire logic clk_in,
  input wire link_cfg_pkg::word_t rdata_in,
  output logic rd_out,
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [3:0] be_out,
  output link_cfg_pkg::word_t wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import link_cfg_pkg::*;
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 8'hFF;
    be_out = 4'h0;
    wdata_out = 32'h0;
  end
  // One write strobe; released address and data lines show the inverse, byte enables hold
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input word_t d);
    @(negedge clk_in);
    wr_out = 1'b1;
    addr_out = a;
    be_out = b;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output word_t d);
    @(negedge clk_in);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask
endmodule // cfg_host_model

// >>> link_cfg_ev_if.sv
// Bus event bundle between the bank top and the flag module
interface link_cfg_ev_if;
  logic [15:0] cmd;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [15:0] flags;
  modport top (output set_vec, output clr_vec, output cmd, input flags);
  modport flg (input set_vec, input clr_vec, input cmd, output flags);
endinterface

// >>> link_cfg_pkg.sv
// Types shared by the config bank modules
package link_cfg_pkg;
  typedef logic [15:0] half_t;
  typedef logic [31:0] word_t;
endpackage

// >>> link_cfg_regs_cfg.svh
// Offsets, field positions, reset values and masks of the link function config bank
`ifndef LINK_CFG_REGS_CFG_SVH
`define LINK_CFG_REGS_CFG_SVH
`define CMD_STS_OFFSET 8'h04
`define CLASS_OFFSET 8'h08
`define CMD_RESET 16'h0000
`define CMD_WRITE_MASK 16'h0156
`define CMD_MEM_BIT 1
`define CMD_INIT_BIT 2
`define CMD_WINV_BIT 4
`define CMD_PAR_BIT 6
`define CMD_SYSF_BIT 8
`define STS_RESET 16'h0210
`define STS_FIXED 16'h0210
`define STS_FLAG_MASK 16'hF900
`define STS_PAR_BIT 15
`define STS_SYSF_BIT 14
`define STS_MABT_BIT 13
`define STS_TABR_BIT 12
`define STS_TABI_BIT 11
`define STS_DPM_BIT 8
`define CLASS_UPPER 24'h0C0010
`endif

// >>> link_function_pci_config_regs.sv
// Command, status and class registers of the link function
`include "link_cfg_regs_cfg.svh"
module link_function_pci_config_regs #(
  parameter logic [7:0] SILICON_VERSION = 8'h00 // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic cfg_rd_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire link_cfg_pkg::word_t cfg_wdata_in,
  output link_cfg_pkg::word_t cfg_rdata_out,
  input wire logic addr_parity_fault_in,
  input wire logic data_parity_fault_in,
  input wire logic perr_seen_in,
  input wire logic master_data_phase_in,
  input wire logic master_abort_in,
  input wire logic target_abort_rx_in,
  input wire logic target_abort_tx_in,
  input wire logic special_cycle_in,
  output logic initiator_en_out,
  output logic mem_space_response_en_out,
  output logic write_invalidate_en_out,
  output logic back_to_back_initiate_en_out,
  output logic port_space_response_en_out,
  output logic special_cycle_claim_out,
  output logic perr_drive_out,
  output logic serr_drive_out
);
  import link_cfg_pkg::*;
  half_t cmd_q;
  half_t cmd_wr;
  half_t sts_clr;
  half_t sts_set;
  word_t rdata_q;
  logic cmd_hit;
  logic cls_hit;
  link_cfg_ev_if ev ();

  localparam logic [7:0] CMD_STS_ADDR = `CMD_STS_OFFSET;
  localparam logic [7:0] CLASS_ADDR = `CLASS_OFFSET;

  // Dword decode only; byte lanes pick the half
  assign cmd_hit = (cfg_addr_in[7:2] == CMD_STS_ADDR[7:2]);
  assign cls_hit = (cfg_addr_in[7:2] == CLASS_ADDR[7:2]);

  // Byte-laned command write
  always_comb begin
    cmd_wr = cmd_q;
    if (cfg_be_in[0]) begin
      cmd_wr[7:0] = cfg_wdata_in[7:0];
    end
    if (cfg_be_in[1]) begin
      cmd_wr[15:8] = cfg_wdata_in[15:8];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cmd_q <= `CMD_RESET;
    end else if (cfg_wr_in && cmd_hit) begin
      cmd_q <= cmd_wr & `CMD_WRITE_MASK;
    end
  end

  // Write-one clears on status bytes
  always_comb begin
    sts_clr = 16'h0000;
    if (cfg_wr_in && cmd_hit) begin
      if (cfg_be_in[2]) begin
        sts_clr[7:0] = cfg_wdata_in[23:16];
      end
      if (cfg_be_in[3]) begin
        sts_clr[15:8] = cfg_wdata_in[31:24];
      end
    end
  end

  always_comb begin
    sts_set = 16'h0000;
    sts_set[`STS_PAR_BIT] = addr_parity_fault_in | data_parity_fault_in;
    sts_set[`STS_SYSF_BIT] = serr_drive_out;
    sts_set[`STS_MABT_BIT] = master_abort_in;
    sts_set[`STS_TABR_BIT] = target_abort_rx_in;
    sts_set[`STS_TABI_BIT] = target_abort_tx_in;
    sts_set[`STS_DPM_BIT] = perr_seen_in & master_data_phase_in
      & cmd_q[`CMD_PAR_BIT];
  end

  assign ev.cmd = cmd_q;
  assign ev.set_vec = sts_set;
  assign ev.clr_vec = sts_clr;

  link_sticky_flags u_flags (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ev(ev)
  );

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h00000000;
    end else if (cfg_rd_in) begin
      if (cmd_hit) begin
        rdata_q <= {ev.flags | `STS_FIXED, cmd_q};
      end else if (cls_hit) begin
        rdata_q <= {`CLASS_UPPER, SILICON_VERSION};
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end
  assign cfg_rdata_out = rdata_q;

  assign initiator_en_out = cmd_q[`CMD_INIT_BIT];
  assign mem_space_response_en_out = cmd_q[`CMD_MEM_BIT];
  assign write_invalidate_en_out = cmd_q[`CMD_WINV_BIT] & cmd_q[`CMD_INIT_BIT];
  assign back_to_back_initiate_en_out = 1'b0;
  assign port_space_response_en_out = 1'b0;
  assign special_cycle_claim_out = 1'b0 & special_cycle_in;
  assign perr_drive_out = cmd_q[`CMD_PAR_BIT] & data_parity_fault_in;
  assign serr_drive_out = cmd_q[`CMD_SYSF_BIT] & addr_parity_fault_in;

  a_cmd_masked: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cmd_q & ~16'h0156) == 16'h0000)
    else $error("hardwired command bit set");
  a_cmd_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cfg_wr_in && cmd_hit && cfg_be_in[0]) |=> cmd_q[2] == $past(cfg_wdata_in[2]))
    else $error("initiator enable not written");
  a_serr_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    serr_drive_out |-> cmd_q[8])
    else $error("system fault driven while disabled");
  a_perr_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    perr_drive_out |-> cmd_q[6])
    else $error("parity fault driven while disabled");
  a_mwi_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    write_invalidate_en_out |-> cmd_q[4])
    else $error("write-invalidate without enable");
  a_abort_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    master_abort_in |=> ev.flags[13])
    else $error("master abort not recorded");
  a_dpm_cond: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (perr_seen_in && master_data_phase_in && cmd_q[6]) |=> ev.flags[8])
    else $error("master data parity not recorded");
  a_sts_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cfg_rd_in && cmd_hit) |=> (cfg_rdata_out[31:16] & 16'h06FF) == 16'h0210)
    else $error("status fixed bits wrong");
  a_class_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cfg_rd_in && cls_hit) |=> cfg_rdata_out[31:8] == 24'h0C0010)
    else $error("class code wrong");

  c_cmd_wr: cover property (@(posedge clk_in) cfg_wr_in && cmd_hit);
  c_clr_flag: cover property (@(posedge clk_in) ev.flags[15] ##1 !ev.flags[15]);
  c_cls_rd: cover property (@(posedge clk_in) cfg_rd_in && cls_hit);
endmodule // link_function_pci_config_regs

// >>> link_sticky_flags.sv
// Sticky status flags, write-one-to-clear, set wins
`include "link_cfg_regs_cfg.svh"
module link_sticky_flags (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  link_cfg_ev_if.flg ev
);
  import link_cfg_pkg::*;
  half_t flags_q;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flags_q <= 16'h0000;
    end else begin
      flags_q <= ((flags_q & ~ev.clr_vec) | ev.set_vec) & `STS_FLAG_MASK;
    end
  end
  assign ev.flags = flags_q;

  a_set_wins: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ev.set_vec[`STS_PAR_BIT]) |=> flags_q[`STS_PAR_BIT])
    else $error("set lost against clear");
  a_clear_one: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ev.clr_vec[`STS_MABT_BIT] && !ev.set_vec[`STS_MABT_BIT]) |=> !flags_q[`STS_MABT_BIT])
    else $error("write one did not clear");
endmodule // link_sticky_flags

// >>> test_link_function_pci_config_regs.sv
// Self-checking bench for the link function config bank
module test_link_function_pci_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import link_cfg_pkg::*;
  localparam logic [7:0] VER = 8'h5A; // Arbitrary value
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic rd, wr;
  logic [7:0] addr, ev, en;
  logic [3:0] be;
  word_t wdata, rdata;
  int num_errors = 0;
  int n_tests = 0;
  always #4 clk_in = ~clk_in;
  cfg_host_model cfg_host_model_i (.clk_in(clk_in), .rdata_in(rdata), .rd_out(rd),
    .wr_out(wr), .addr_out(addr), .be_out(be), .wdata_out(wdata));
  link_function_pci_config_regs #(.SILICON_VERSION(VER)) link_function_pci_config_regs_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_rd_in(rd), .cfg_wr_in(wr),
    .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata),
    .addr_parity_fault_in(ev[7]), .data_parity_fault_in(ev[6]), .perr_seen_in(ev[5]),
    .master_data_phase_in(ev[4]), .master_abort_in(ev[3]), .target_abort_rx_in(ev[2]),
    .target_abort_tx_in(ev[1]), .special_cycle_in(ev[0]),
    .initiator_en_out(en[7]), .mem_space_response_en_out(en[6]),
    .write_invalidate_en_out(en[5]), .back_to_back_initiate_en_out(en[4]),
    .port_space_response_en_out(en[3]), .special_cycle_claim_out(en[2]),
    .perr_drive_out(en[1]), .serr_drive_out(en[0]));
  task automatic chk(input string what, input word_t exp, input word_t got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rc(input logic [7:0] a, input word_t exp);
    word_t d;
    cfg_host_model_i.rd(a, d);
    chk("read data", exp, d);
  endtask
  // One-cycle event pulse; enables checked while it stands
  task automatic pulse(input logic [7:0] v, input logic [7:0] exp);
    @(negedge clk_in);
    ev = v;
    #1;
    chk("enables", {24'h0, exp}, {24'h0, en});
    @(negedge clk_in);
    ev = 8'h00;
  endtask
  task automatic t_reset;
    rc(8'h04, 32'h0210_0000);
    rc(8'h08, {24'h0C0010, VER});
    rc(8'h0C, 32'h0);
    pulse(8'h00, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_cmd;
    cfg_host_model_i.wr(8'h04, 4'h3, 32'h0000_FFFF);
    rc(8'h04, 32'h0210_0156);
    pulse(8'h01, 8'hE0);
    cfg_host_model_i.wr(8'h08, 4'hF, 32'hFFFF_FFFF);
    rc(8'h08, {24'h0C0010, VER});
    $display("test command done");
  endtask
  task automatic t_flags;
    pulse(8'h80, 8'hE1);
    pulse(8'h70, 8'hE2);
    pulse(8'h0E, 8'hE0);
    rc(8'h04, 32'hFB10_0156);
    cfg_host_model_i.wr(8'h04, 4'h8, 32'h2000_0000);
    rc(8'h04, 32'hDB10_0156);
    cfg_host_model_i.wr(8'h04, 4'hC, 32'hFFFF_0000);
    rc(8'h04, 32'h0210_0156);
    $display("test flags done");
  endtask
  task automatic t_gate;
    cfg_host_model_i.wr(8'h04, 4'h3, 32'h0000_0002);
    pulse(8'h70, 8'h40);
    pulse(8'h80, 8'h40);
    rc(8'h04, 32'h8210_0002);
    $display("test gating done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    ev = 8'h00;
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_cmd();
    t_flags();
    t_gate();
    complete_run();
  end
  initial begin
    #50000;
    num_errors++;
    complete_run();
  end
endmodule // test_link_function_pci_config_regs
